// >>> hw/can_irq_consts.vh
// Constants for the CAN interrupt enable and priority block
//
// Functional notes
// - Transmit buffer 2 enable bit passes its request at 1, blocks at 0
// - Enable bit 3 gates transmit buffer 1 request: 1 passes, 0 blocks
// - Enable bit 2 gates transmit buffer 0 request: 1 passes, 0 blocks
// - Enable bit 1 gates receive buffer 1 request: 1 passes, 0 blocks
// - Enable bit 0 gates receive buffer 0 request: 1 passes, 0 blocks
// - Priority bit 6 sends wake-up request high at 1, low at 0
// - Priority bit 5 sends bus error request high at 1, low at 0
// - Enable bits 7, 6, 5 gate invalid message, wake-up, bus error
`ifndef CAN_IRQ_CONSTS_VH
`define CAN_IRQ_CONSTS_VH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define OFS_IRQ_ENABLE    8'h00
`define OFS_IRQ_PRIORITY  8'h04
`define OFS_REQ_RAW       8'h08
`define OFS_REQ_ROUTED    8'h0C
`define OFS_EVT_STATUS    8'h10
`define OFS_EVT_MASK      8'h14
`define OFS_VECTOR        8'h18

////////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_IRQ_ENABLE    8'h00
`define RST_IRQ_PRIORITY  8'h00
`define RST_EVT_STATUS    8'h00
`define RST_EVT_MASK      8'h00
`define RST_PRDATA        32'h0000_0000

////////////////////////////////////////////////////////////////////////////
// Source bit positions, shared by every 8-bit register
`define BIT_RX_BUF0       0
`define BIT_RX_BUF1       1
`define BIT_TX_BUF0       2
`define BIT_TX_BUF1       3
`define BIT_TX_BUF2       4
`define BIT_BUS_ERROR     5
`define BIT_WAKEUP        6
`define BIT_INVALID_MSG   7
`define NUM_SRC           8

////////////////////////////////////////////////////////////////////////////
// Field positions of routed and vector registers
`define ROUTED_LO_LSB     0
`define ROUTED_HI_LSB     8
`define VEC_HI_LSB        0
`define VEC_HI_VALID      3
`define VEC_LO_LSB        8
`define VEC_LO_VALID      11

`endif

// >>> hw/sticky_w1c.v
// Sticky event flags, set by hardware, cleared by writing one
`timescale 1ns/10ps
module sticky_w1c #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         clk_sys,
    input  wire         sys_rst,
    // Set and clear
    input  wire [W-1:0] set,
    input  wire [W-1:0] clr,
    // Flags
    output wire [W-1:0] flag
);

    reg [W-1:0] flag_q;

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            // Set wins over a same-cycle clear
            always @(posedge clk_sys) begin
                if (sys_rst) begin
                    flag_q[i] <= 1'b0;
                end else if (set[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (clr[i]) begin
                    flag_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign flag = flag_q;

endmodule // sticky_w1c

// >>> hw/irq_route.v
// Per-source enable gating and high or low priority routing
`timescale 1ns/10ps
module irq_route #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         clk_sys,
    input  wire         sys_rst,
    // Requests and controls
    input  wire [W-1:0] req,
    input  wire [W-1:0] en,
    input  wire [W-1:0] prio,
    // Routed requests
    output wire [W-1:0] hi_vec,
    output wire [W-1:0] lo_vec,
    output wire         hi_any,
    output wire         lo_any
);

    reg  [W-1:0] hi_q;
    reg  [W-1:0] lo_q;
    wire [W-1:0] hi_d;
    wire [W-1:0] lo_d;

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_src
            // Enable gates, priority picks the vector
            assign hi_d[i] = req[i] & en[i] & prio[i];
            assign lo_d[i] = req[i] & en[i] & ~prio[i];
        end
    endgenerate

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            hi_q <= {W{1'b0}};
            lo_q <= {W{1'b0}};
        end else begin
            hi_q <= hi_d;
            lo_q <= lo_d;
        end
    end

    assign hi_vec = hi_q;
    assign lo_vec = lo_q;
    assign hi_any = |hi_q;
    assign lo_any = |lo_q;

endmodule // irq_route

// >>> hw/can_irq_enable_priority.v
// CAN interrupt enable, priority routing and event registers on APB
`timescale 1ns/10ps
`include "can_irq_consts.vh"
module can_irq_enable_priority (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        sys_rst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output wire [31:0] prdata,
    output wire        pslverr,
    // Source requests from the flag logic
    input  wire [7:0]  src_req,
    // Processor interrupt lines
    output wire        irq_high,
    output wire        irq_low,
    // Summary event interrupt
    output wire        irq
);

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Register select: one bit per mapped offset
    function [6:0] reg_sel;
        input [7:0] addr;
        begin
            reg_sel = 7'h00;
            case (addr)
                `OFS_IRQ_ENABLE: begin
                    reg_sel = 7'h01;
                end
                `OFS_IRQ_PRIORITY: begin
                    reg_sel = 7'h02;
                end
                `OFS_REQ_RAW: begin
                    reg_sel = 7'h04;
                end
                `OFS_REQ_ROUTED: begin
                    reg_sel = 7'h08;
                end
                `OFS_EVT_STATUS: begin
                    reg_sel = 7'h10;
                end
                `OFS_EVT_MASK: begin
                    reg_sel = 7'h20;
                end
                `OFS_VECTOR: begin
                    reg_sel = 7'h40;
                end
                default: begin
                    reg_sel = 7'h00;
                end
            endcase
        end
    endfunction

    // Lowest-numbered active source: valid bit and index
    function [3:0] first_src;
        input [7:0] vec;
        integer k;
        begin
            first_src = 4'h0;
            for (k = `NUM_SRC - 1; k >= 0; k = k - 1) begin
                if (vec[k]) begin
                    first_src = {1'b1, k[2:0]};
                end
            end
        end
    endfunction

    // One register byte placed in the low lane of a bus word
    function [31:0] byte_word;
        input [7:0] b;
        begin
            byte_word = {24'h00_0000, b};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    reg  [7:0]  enable_q;
    reg  [7:0]  priority_q;
    reg  [7:0]  evt_mask_q;
    reg  [7:0]  src_req_q;
    reg  [31:0] prdata_q;
    reg  [31:0] prdata_d;
    reg         pslverr_q;
    reg         irq_q;
    reg  [7:0]  evt_clr;
    wire [6:0]  sel;
    wire        setup;
    wire        wr_acc;
    wire        lane0;
    wire [7:0]  evt_set;
    wire [7:0]  evt_flag;
    wire [7:0]  hi_vec;
    wire [7:0]  lo_vec;
    wire        hi_any;
    wire        lo_any;
    wire [3:0]  hi_first;
    wire [3:0]  lo_first;
    wire        wr_enable;
    wire        wr_priority;
    wire        wr_status;
    wire        wr_mask;
    wire        hi_valid;
    wire [2:0]  hi_idx;
    wire        lo_valid;
    wire [2:0]  lo_idx;
    wire [7:0]  evt_pend;

    ////////////////////////////////////////////////////////////////////////
    // APB phase decode

    assign sel    = reg_sel(paddr);
    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign lane0  = pstrb[0];

    ////////////////////////////////////////////////////////////////////////
    // Per-register write strobes on the low byte lane
    assign wr_enable   = wr_acc & lane0 & sel[0];
    assign wr_priority = wr_acc & lane0 & sel[1];
    assign wr_status   = wr_acc & lane0 & sel[4];
    assign wr_mask     = wr_acc & lane0 & sel[5];

    // Zero wait states
    assign pready = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Writable registers

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            enable_q <= `RST_IRQ_ENABLE;
        end else if (wr_enable) begin
            enable_q <= pwdata[7:0];
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            priority_q <= `RST_IRQ_PRIORITY;
        end else if (wr_priority) begin
            priority_q <= pwdata[7:0];
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            evt_mask_q <= `RST_EVT_MASK;
        end else if (wr_mask) begin
            evt_mask_q <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event flags: rising edge of each source request

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            src_req_q <= 8'h00;
        end else begin
            src_req_q <= src_req;
        end
    end

    genvar s;
    generate
        for (s = 0; s < `NUM_SRC; s = s + 1) begin : g_edge
            assign evt_set[s] = src_req[s] & ~src_req_q[s];
        end
    endgenerate

    always @* begin
        evt_clr = 8'h00;
        if (wr_status) begin
            evt_clr = pwdata[7:0];
        end
    end

    sticky_w1c #(
        .W       (8)
    ) u_evt (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .set     (evt_set),
        .clr     (evt_clr),
        .flag    (evt_flag)
    );

    ////////////////////////////////////////////////////////////////////////
    // Enable gating and priority routing

    irq_route #(
        .W       (8)
    ) u_route (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .req     (src_req),
        .en      (enable_q),
        .prio    (priority_q),
        .hi_vec  (hi_vec),
        .lo_vec  (lo_vec),
        .hi_any  (hi_any),
        .lo_any  (lo_any)
    );

    assign irq_high = hi_any;
    assign irq_low  = lo_any;

    assign hi_first = first_src(hi_vec);
    assign lo_first = first_src(lo_vec);

    ////////////////////////////////////////////////////////////////////////
    // Vector register fields

    assign hi_valid = hi_first[3];
    assign hi_idx   = hi_first[2:0];
    assign lo_valid = lo_first[3];
    assign lo_idx   = lo_first[2:0];

    ////////////////////////////////////////////////////////////////////////
    // Summary interrupt

    assign evt_pend = evt_flag & evt_mask_q;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |evt_pend;
        end
    end

    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup cycle

    always @* begin
        prdata_d = `RST_PRDATA;
        case (sel)
            7'h01: begin
                prdata_d = byte_word(enable_q);
            end
            7'h02: begin
                prdata_d = byte_word(priority_q);
            end
            7'h04: begin
                prdata_d = byte_word(src_req);
            end
            7'h08: begin
                prdata_d[`ROUTED_LO_LSB +: 8] = lo_vec;
                prdata_d[`ROUTED_HI_LSB +: 8] = hi_vec;
            end
            7'h10: begin
                prdata_d = byte_word(evt_flag);
            end
            7'h20: begin
                prdata_d = byte_word(evt_mask_q);
            end
            7'h40: begin
                prdata_d[`VEC_HI_LSB +: 3] = hi_idx;
                prdata_d[`VEC_HI_VALID]    = hi_valid;
                prdata_d[`VEC_LO_LSB +: 3] = lo_idx;
                prdata_d[`VEC_LO_VALID]    = lo_valid;
            end
            default: begin
                prdata_d = `RST_PRDATA;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            prdata_q <= `RST_PRDATA;
        end else if (setup) begin
            prdata_q <= pwrite ? `RST_PRDATA : prdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error response for unmapped offsets

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pslverr_q <= ~|sel;
        end
    end

    assign prdata  = prdata_q;
    assign pslverr = pslverr_q & psel & penable;

endmodule // can_irq_enable_priority

// >>> dv/can_irq_checker_properties.sv
// Port assertions for the CAN interrupt enable and priority block
`timescale 1ns/10ps
module can_irq_checker (
    // Clock and reset
    input wire        clk_sys,
    input wire        sys_rst,
    // APB slave
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    // Requests and interrupt lines
    input wire [7:0]  src_req,
    input wire        irq_high,
    input wire        irq_low,
    input wire        irq
);
    reg  [7:0] en_q;
    reg  [7:0] pr_q;
    wire [7:0] hot = src_req & en_q;
    // Shadow of enable and priority
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            en_q <= 8'h00;
            pr_q <= 8'h00;
        end else if (psel && penable && pwrite && pstrb[0]) begin
            if (paddr == 8'h00) en_q <= pwdata[7:0];
            if (paddr == 8'h04) pr_q <= pwdata[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    tx2_high_a: assert property (hot[4] && pr_q[4] |=> irq_high)
        else $error("tx2 not high");
    tx1_low_a: assert property (hot[3] && !pr_q[3] |=> irq_low)
        else $error("tx1 not low");
    tx0_high_a: assert property (hot[2] && pr_q[2] |=> irq_high)
        else $error("tx0 not high");
    rx1_low_a: assert property (hot[1] && !pr_q[1] |=> irq_low)
        else $error("rx1 not low");
    rx0_high_a: assert property (hot[0] && pr_q[0] |=> irq_high)
        else $error("rx0 not high");
    wake_high_a: assert property (hot[6] && pr_q[6] |=> irq_high)
        else $error("wake not high");
    err_low_a: assert property (hot[5] && !pr_q[5] |=> irq_low)
        else $error("error not low");
    inv_msg_a: assert property (hot[7] |=> irq_high || irq_low)
        else $error("invalid message request lost");
    high_quiet_a: assert property (!(|(hot & pr_q)) |=> !irq_high)
        else $error("high line without cause");
    low_quiet_a: assert property (!(|(hot & ~pr_q)) |=> !irq_low)
        else $error("low line without cause");
endmodule // can_irq_checker

bind can_irq_enable_priority can_irq_checker i_can_irq_checker (
    .clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .src_req, .irq_high, .irq_low, .irq
);

// >>> dv/irq_vector_model.sv
// Processor side model taking the high or low interrupt vector
`timescale 1ns/10ps
module irq_vector_model (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       sys_rst,
    // Interrupt lines
    input  wire       irq_high,
    input  wire       irq_low,
    // Vector taken: 2 high, 1 low, 0 none
    output reg  [1:0] vector_q
);
    // High line preempts low
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            vector_q <= 2'h0;
        end else begin
            vector_q <= irq_high ? 2'h2 : {1'b0, irq_low};
        end
    end
endmodule // irq_vector_model

// >>> dv/can_irq_enable_priority_test.sv
// Self-checking bench for the CAN interrupt enable and priority block
`timescale 1ns/10ps
`include "can_irq_consts.vh"
module can_irq_enable_priority_test;
    reg         clk_sys = 1'b0;
    reg         sys_rst = 1'b1;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0000_0000;
    reg  [7:0]  src_req = 8'h00;
    reg  [3:0]  pstrb = 4'h1;
    wire        pready;
    wire [31:0] prdata;
    wire        pslverr;
    wire        irq_high;
    wire        irq_low;
    wire        irq;
    wire [1:0]  vector_q;
    reg  [31:0] rd;
    reg  [31:0] r32;
    reg         err;
    integer     error_cnt = 0;
    integer     n_checks = 0;
    integer     i;
    can_irq_enable_priority i_can_irq_enable_priority (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .src_req(src_req), .irq_high(irq_high),
        .irq_low(irq_low), .irq(irq));
    irq_vector_model i_irq_vector_model (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .irq_high(irq_high), .irq_low(irq_low),
        .vector_q(vector_q));
    initial forever #2 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", n_checks, error_cnt);
            if (error_cnt == 0 && n_checks > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        integer k;
        begin
            @(posedge clk_sys);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk_sys);
            penable <= 1'b1;
            k = 0;
            @(posedge clk_sys);
            while (pready !== 1'b1 && k < 20) begin
                @(posedge clk_sys);
                k = k + 1;
            end
            if (pready !== 1'b1) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0t no pready", $time);
                report_and_stop;
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    function [1:0] exp_lines(input [7:0] r, input [7:0] e, input [7:0] p);
        exp_lines = {|(r & e & p), |(r & e & ~p)};
    endfunction
    function [3:0] low_idx(input [7:0] v);
        integer n;
        begin
            low_idx = 4'h0;
            for (n = 0; n < 8; n = n + 1) begin
                if (v[n] && !low_idx[3]) begin
                    low_idx = {1'b1, n[2:0]};
                end
            end
        end
    endfunction
    task route(input [7:0] e, input [7:0] p, input [7:0] r);
        reg [1:0] l;
        begin
            l = exp_lines(r, e, p);
            apb(1'b1, `OFS_IRQ_ENABLE, {24'h0, e});
            apb(1'b1, `OFS_IRQ_PRIORITY, {24'h0, p});
            src_req <= r;
            repeat (2) @(posedge clk_sys);
            @(negedge clk_sys);
            chk({30'h0, irq_high, irq_low}, {30'h0, l});
            @(negedge clk_sys);
            chk({30'h0, vector_q}, l[1] ? 32'h2 : {31'h0, l[0]});
            apb(1'b0, `OFS_IRQ_ENABLE, 32'h0);
            chk(rd, {24'h0, e});
            apb(1'b0, `OFS_IRQ_PRIORITY, 32'h0);
            chk(rd, {24'h0, p});
            apb(1'b0, `OFS_REQ_RAW, 32'h0);
            chk(rd, {24'h0, r});
            apb(1'b0, `OFS_REQ_ROUTED, 32'h0);
            chk(rd, {16'h0, r & e & p, r & e & ~p});
            apb(1'b0, `OFS_VECTOR, 32'h0);
            chk(rd, {20'h0, low_idx(r & e & ~p), 4'h0, low_idx(r & e & p)});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        r32 = $urandom(32'hb65d);
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        // Reset value and unmapped place
        apb(1'b0, `OFS_IRQ_PRIORITY, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, err}, 32'h1);
        // One source enabled at a time, both routes, then 40 random settings
        for (i = 0; i < 16; i = i + 1) begin
            route(8'h01 << i[2:0], {8{i[3]}}, 8'hFF);
        end
        for (i = 0; i < 40; i = i + 1) begin
            r32 = $urandom;
            route(r32[7:0], r32[15:8], r32[23:16]);
        end
        // Event flag, mask and write-one clear
        src_req <= 8'h00;
        apb(1'b1, `OFS_EVT_STATUS, 32'h0000_00FF);
        apb(1'b1, `OFS_EVT_MASK, 32'h0000_0001);
        src_req <= 8'h01;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, `OFS_EVT_STATUS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, `OFS_EVT_MASK, 32'h0);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `OFS_EVT_STATUS, 32'h1);
        apb(1'b0, `OFS_EVT_STATUS, 32'h0);
        chk(rd, 32'h0);
        // Write with the low lane strobe off is dropped
        apb(1'b1, `OFS_IRQ_ENABLE, 32'h0000_005A);
        apb(1'b1, `OFS_IRQ_PRIORITY, 32'h0000_00C3);
        pstrb <= 4'h0;
        apb(1'b1, `OFS_IRQ_ENABLE, 32'h0000_00A5);
        pstrb <= 4'h1;
        apb(1'b0, `OFS_IRQ_ENABLE, 32'h0);
        chk(rd, 32'h0000_005A);
        // Reset in mid-run clears both control registers
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(1'b0, `OFS_IRQ_ENABLE, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `OFS_IRQ_PRIORITY, 32'h0);
        chk(rd, 32'h0);
        @(negedge clk_sys);
        chk({30'h0, irq_high, irq_low}, 32'h0);
        report_and_stop;
    end
endmodule // can_irq_enable_priority_test
